// ---- gpio_report_pkg.sv ----
/*
  gpio_report_pkg: timing, register map, field layout, message text
  and types of the port report block.
  assumes a 50 MHz system clock shared by every user of the block.
*/
package gpio_report_pkg;
  localparam int CLK_HZ       = 50_000_000;
  // led flicker half period, also the grain of every slow timer
  localparam int FAST_MS      = 100;
  localparam int FAST_CYC     = CLK_HZ / 1000 * FAST_MS;
  localparam int TICKS_PER_S  = 1000 / FAST_MS;
  localparam int NETCHK_S     = 4;
  localparam int WAKE_S       = 1;
  localparam int NETCHK_TICKS = NETCHK_S * TICKS_PER_S;
  localparam int WAKE_TICKS   = WAKE_S * TICKS_PER_S;
  localparam int TICK_W       = 8;
  localparam int SUB_W        = 4;
  localparam int VAL_W        = 16;
  localparam int SRC_W        = 64;
  localparam int ADDR_W       = 4;
  localparam int DATA_W       = 16;
  localparam int CH_W         = 8;
  localparam int IDX_W        = 5;

  localparam logic [ADDR_W-1:0] A_CTRL     = 4'h0;
  localparam logic [ADDR_W-1:0] A_INTERVAL = 4'h1;
  localparam logic [ADDR_W-1:0] A_STATUS   = 4'h2;
  localparam logic [ADDR_W-1:0] A_RXVAL    = 4'h3;
  localparam logic [ADDR_W-1:0] A_COUNT    = 4'h4;

  localparam int CTRL_W = 7;
  localparam int C_DIR  = 0;
  localparam int C_KEY  = 2;
  localparam int C_ADC  = 3;
  localparam int C_CNT  = 4;
  localparam int C_END  = 5;
  localparam int C_TGT  = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  localparam int INTV_W = 8;
  localparam logic [INTV_W-1:0] INTV_RST = 8'h00;
  localparam logic [1:0] DIR_IN  = 2'h1;
  localparam logic [1:0] DIR_OUT = 2'h2;

  localparam int STAT_W  = 6;
  localparam int S_CHECK = 0;
  localparam int S_SLEEP = 1;
  localparam int S_NET   = 2;
  localparam int S_BUSY  = 3;
  localparam int S_OK    = 4;
  localparam int S_ERR   = 5;

  localparam int OK_LEN  = 17;
  localparam int ERR_LEN = 20;
  localparam logic [8*OK_LEN-1:0]  MSG_OK_TXT  = "ROUTER START OK\r\n";
  localparam logic [8*ERR_LEN-1:0] MSG_ERR_TXT = "ROUTER START ERROR\r\n";
  localparam logic [23:0] TAG_TXT    = 24'h475054;
  localparam int REP_HEX_AT = 3;
  localparam int REP_US_AT  = 7;
  localparam int REP_SRC_AT = 8;
  localparam int REP_CR_AT  = 24;
  localparam int REP_LEN    = 26;
  localparam logic [7:0] CH_US  = 8'h5f;
  localparam logic [7:0] CH_CR  = 8'h0d;
  localparam logic [7:0] CH_LF  = 8'h0a;
  localparam logic [7:0] CH_0   = 8'h30;
  localparam logic [7:0] CH_A10 = 8'h37;

  typedef enum logic [1:0] {KIND_KEY, KIND_GPIO, KIND_ADC, KIND_CNT} kind_t;
  typedef enum logic [1:0] {PH_CHECK, PH_RUN, PH_SLEEP, PH_AWAKE} phase_t;
  typedef enum logic [1:0] {MSG_NONE, MSG_OK, MSG_ERR, MSG_REP} msg_t;
endpackage

// ---- pin_sync2.sv ----
/*
  pin_sync2: two flip-flop synchroniser for a group of static pins.
  assumes each bit is a slow level; multi-bit skew is tolerated.
*/
`timescale 1ns/100ps
module pin_sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_r <= '0;
      o_q    <= '0;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end
endmodule

// ---- gpio_report_select.sv ----
/*
  gpio_report_select: picks what a key press or interval expiry sends
  to the paired target, prints received port reports on the serial
  stream and drives them onto the port, and runs the power-up check,
  the end-device sleep window and the leds.
  assumes radio, adc and serial sender run on I_MCLK; key, wake,
  network and port pins are asynchronous.
*/
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/100ps
module gpio_report_select #(
  parameter int FAST_CYC = gpio_report_pkg::FAST_CYC
) (
  input  wire logic        I_MCLK,
  input  wire logic        I_RST,
  input  wire logic [3:0]  I_ADDR,
  input  wire logic [15:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [15:0] O_RDATA,
  input  wire logic        I_KEY_N,
  input  wire logic        I_WAKE_N,
  input  wire logic        I_NET_UP,
  input  wire logic [15:0] I_GPIO,
  output logic      [15:0] O_GPIO,
  output logic             O_GPIO_OE_N,
  input  wire logic [15:0] I_ADC,
  output logic             O_TX_VALID,
  output logic      [1:0]  O_TX_KIND,
  output logic      [15:0] O_TX_DATA,
  input  wire logic        I_LINK_DONE,
  input  wire logic        I_LINK_OK,
  input  wire logic        I_RX_VALID,
  input  wire logic [15:0] I_RX_DATA,
  input  wire logic [63:0] I_RX_SRC,
  output logic             O_CH_VALID,
  output logic      [7:0]  O_CH_DATA,
  input  wire logic        I_CH_READY,
  output logic             O_STATUS_LED,
  output logic             O_OK_LED,
  output logic             O_ERR_LED,
  output logic             O_SLEEP
);
  localparam int PRE_W = $clog2(FAST_CYC);
  localparam int TW    = gpio_report_pkg::TICK_W;
  localparam int SW    = gpio_report_pkg::SUB_W;
  localparam int IW    = gpio_report_pkg::IDX_W;
  localparam int PW    = gpio_report_pkg::VAL_W + 3;

  logic [PW-1:0]  pins_s;
  logic           key_n_s;
  logic           wake_n_s;
  logic           net_s;
  logic [15:0]    gpio_s;

  pin_sync2 #(.W(PW)) u_sync (
    .i_clk (I_MCLK),
    .i_rst (I_RST),
    .i_d   ({I_KEY_N, I_WAKE_N, I_NET_UP, I_GPIO}),
    .o_q   (pins_s)
  );
  assign {key_n_s, wake_n_s, net_s, gpio_s} = pins_s;

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);

  // timing and phase
  logic [PRE_W-1:0]         pre_r, pre_nxt;
  logic                     tick_r, tick_nxt;
  logic [SW-1:0]            sub_r, sub_nxt;
  logic                     sec_r, sec_nxt;
  logic [TW-1:0]            pcnt_r, pcnt_nxt;
  gpio_report_pkg::phase_t  phase_r, phase_nxt;
  logic                     wake_prev_r;
  logic                     sleep_r;
  logic                     chk_done;
  logic                     sleep_cfg;
  logic [gpio_report_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;

  assign sleep_cfg = ctrl_r[gpio_report_pkg::C_END]
                   & ctrl_r[gpio_report_pkg::C_TGT];

  always_comb begin
    pre_nxt   = pre_r + 1'b1;
    tick_nxt  = 1'b0;
    sub_nxt   = sub_r;
    sec_nxt   = 1'b0;
    pcnt_nxt  = pcnt_r;
    phase_nxt = phase_r;
    chk_done  = 1'b0;
    if (pre_r == PRE_W'(FAST_CYC - 1)) begin
      pre_nxt  = '0;
      tick_nxt = 1'b1;
    end
    if (tick_r) begin
      pcnt_nxt = pcnt_r + 1'b1;
      if (sub_r == SW'(gpio_report_pkg::TICKS_PER_S - 1)) begin
        sub_nxt = '0;
        sec_nxt = 1'b1;
      end else begin
        sub_nxt = sub_r + 1'b1;
      end
    end
    case (phase_r)
      gpio_report_pkg::PH_CHECK: begin
        if (tick_r && pcnt_r == TW'(gpio_report_pkg::NETCHK_TICKS - 1)) begin
          phase_nxt = gpio_report_pkg::PH_RUN;
          chk_done  = 1'b1;
        end
      end
      gpio_report_pkg::PH_RUN: begin
        if (sleep_cfg) begin
          phase_nxt = gpio_report_pkg::PH_SLEEP;
        end
      end
      gpio_report_pkg::PH_SLEEP: begin
        if (!sleep_cfg) begin
          phase_nxt = gpio_report_pkg::PH_RUN;
        end else if (wake_prev_r && !wake_n_s) begin
          phase_nxt = gpio_report_pkg::PH_AWAKE;
          pcnt_nxt  = '0;
        end
      end
      default: begin
        if (!sleep_cfg) begin
          phase_nxt = gpio_report_pkg::PH_RUN;
        end else if (tick_r &&
                     pcnt_r == TW'(gpio_report_pkg::WAKE_TICKS - 1)) begin
          phase_nxt = gpio_report_pkg::PH_SLEEP;
        end
      end
    endcase
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      pre_r       <= '0;
      tick_r      <= 1'b0;
      sub_r       <= '0;
      sec_r       <= 1'b0;
      pcnt_r      <= '0;
      phase_r     <= gpio_report_pkg::PH_CHECK;
      wake_prev_r <= 1'b0;
      sleep_r     <= 1'b0;
    end else begin
      pre_r       <= pre_nxt;
      tick_r      <= tick_nxt;
      sub_r       <= sub_nxt;
      sec_r       <= sec_nxt;
      pcnt_r      <= pcnt_nxt;
      phase_r     <= phase_nxt;
      wake_prev_r <= wake_n_s;
      sleep_r     <= (phase_nxt == gpio_report_pkg::PH_SLEEP);
    end
  end

  wake_bound_a: assert property (phase_r == gpio_report_pkg::PH_AWAKE
    |-> pcnt_r < TW'(gpio_report_pkg::WAKE_TICKS))
    else $error("awake window overran one second");

  // configuration and sending
  logic [gpio_report_pkg::INTV_W-1:0] intv_r, intv_nxt;
  logic [gpio_report_pkg::INTV_W-1:0] icnt_r, icnt_nxt;
  logic        key_prev_r, busy_r, busy_nxt, ok_r, ok_nxt, err_r, err_nxt;
  logic [15:0] cnt_r, cnt_nxt, txd_r, txd_nxt;
  logic        txv_r, txv_nxt;
  gpio_report_pkg::kind_t kind_r, kind_nxt;
  logic        cfg_ok, key_fall, fire, can_tx, dir_in;

  assign cfg_ok   = (phase_r == gpio_report_pkg::PH_RUN)
                 || (phase_r == gpio_report_pkg::PH_AWAKE);
  assign key_fall = key_prev_r & ~key_n_s;
  assign dir_in   = (ctrl_r[1:0] == gpio_report_pkg::DIR_IN);
  assign fire     = sec_r && ctrl_r[gpio_report_pkg::C_ADC]
                 && intv_r != '0 && icnt_r == intv_r - 1'b1;
  // a send while the previous result is pending is dropped
  assign can_tx   = !busy_r && phase_r != gpio_report_pkg::PH_CHECK;

  always_comb begin
    ctrl_nxt = ctrl_r;
    intv_nxt = intv_r;
    icnt_nxt = icnt_r;
    if (I_WR && cfg_ok) begin
      if (I_ADDR == gpio_report_pkg::A_CTRL) begin
        ctrl_nxt = I_WDATA[gpio_report_pkg::CTRL_W-1:0];
      end else if (I_ADDR == gpio_report_pkg::A_INTERVAL) begin
        intv_nxt = I_WDATA[gpio_report_pkg::INTV_W-1:0];
      end
    end
    if (intv_nxt != intv_r || !ctrl_r[gpio_report_pkg::C_ADC] || fire) begin
      icnt_nxt = '0;
    end else if (sec_r) begin
      icnt_nxt = icnt_r + 1'b1;
    end
    txv_nxt  = 1'b0;
    kind_nxt = kind_r;
    txd_nxt  = txd_r;
    cnt_nxt  = cnt_r;
    if (can_tx && key_fall && ctrl_r[gpio_report_pkg::C_KEY]) begin
      txv_nxt  = 1'b1;
      kind_nxt = dir_in ? gpio_report_pkg::KIND_GPIO
                        : gpio_report_pkg::KIND_KEY;
      txd_nxt  = dir_in ? gpio_s : '0;
    end else if (can_tx && fire) begin
      txv_nxt = 1'b1;
      if (ctrl_r[gpio_report_pkg::C_CNT]) begin
        kind_nxt = gpio_report_pkg::KIND_CNT;
        cnt_nxt  = cnt_r + 1'b1;
        txd_nxt  = cnt_r + 1'b1;
      end else if (dir_in) begin
        kind_nxt = gpio_report_pkg::KIND_GPIO;
        txd_nxt  = gpio_s;
      end else begin
        kind_nxt = gpio_report_pkg::KIND_ADC;
        txd_nxt  = I_ADC;
      end
    end
    busy_nxt = busy_r;
    ok_nxt   = ok_r;
    err_nxt  = err_r;
    // a link result landing in the same cycle still wins over the clear
    if (ctrl_nxt[gpio_report_pkg::C_TGT]
        && !ctrl_r[gpio_report_pkg::C_TGT]) begin
      ok_nxt  = 1'b0;
      err_nxt = 1'b0;
    end
    if (txv_nxt) begin
      busy_nxt = 1'b1;
      ok_nxt   = 1'b0;
      err_nxt  = 1'b0;
    end else if (busy_r && I_LINK_DONE) begin
      busy_nxt = 1'b0;
      ok_nxt   = I_LINK_OK;
      err_nxt  = !I_LINK_OK;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      ctrl_r     <= gpio_report_pkg::CTRL_RST;
      intv_r     <= gpio_report_pkg::INTV_RST;
      icnt_r     <= '0;
      key_prev_r <= 1'b0;
      busy_r     <= 1'b0;
      ok_r       <= 1'b0;
      err_r      <= 1'b0;
      cnt_r      <= '0;
      txv_r      <= 1'b0;
      kind_r     <= gpio_report_pkg::KIND_KEY;
      txd_r      <= '0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      intv_r     <= intv_nxt;
      icnt_r     <= icnt_nxt;
      key_prev_r <= key_n_s;
      busy_r     <= busy_nxt;
      ok_r       <= ok_nxt;
      err_r      <= err_nxt;
      cnt_r      <= cnt_nxt;
      txv_r      <= txv_nxt;
      kind_r     <= kind_nxt;
      txd_r      <= txd_nxt;
    end
  end

  assign O_TX_VALID = txv_r;
  assign O_TX_KIND  = kind_r;
  assign O_TX_DATA  = txd_r;
  assign O_OK_LED   = ok_r;
  assign O_ERR_LED  = err_r;
  assign O_SLEEP    = sleep_r;

  key_gpio_a: assert property (can_tx && key_fall && dir_in
    && ctrl_r[gpio_report_pkg::C_KEY] |=> O_TX_VALID
    && O_TX_KIND == gpio_report_pkg::KIND_GPIO && O_TX_DATA == $past(gpio_s))
    else $error("key press did not send port value");
  timer_gpio_a: assert property (can_tx && fire && dir_in && !key_fall
    && !ctrl_r[gpio_report_pkg::C_CNT] |=> O_TX_VALID
    && O_TX_KIND == gpio_report_pkg::KIND_GPIO)
    else $error("interval did not send port value");
  interval_a: assert property (ctrl_r[gpio_report_pkg::C_ADC]
    && intv_r != '0 |-> icnt_r < intv_r)
    else $error("interval count passed its period");
  count_first_a: assert property (can_tx && fire && !key_fall
    && ctrl_r[gpio_report_pkg::C_CNT]
    |=> O_TX_KIND == gpio_report_pkg::KIND_CNT)
    else $error("counter report lost priority");
  check_cfg_a: assert property (phase_r == gpio_report_pkg::PH_CHECK
    |=> $stable(ctrl_r) && $stable(intv_r))
    else $error("configuration changed during network check");
  sleep_cfg_a: assert property (phase_r == gpio_report_pkg::PH_SLEEP
    && I_WR |=> $stable(ctrl_r) && $stable(intv_r))
    else $error("configuration taken while asleep");
  busy_hold_a: assert property (busy_r && !I_LINK_DONE |=> !O_TX_VALID)
    else $error("send issued before previous result");

  // received reports, serial text and port drive
  gpio_report_pkg::msg_t msg_r, msg_nxt;
  logic [IW-1:0] idx_r, idx_nxt;
  logic [15:0]   rxv_r, rxv_nxt, gpo_r, gpo_nxt;
  logic [63:0]   src_r, src_nxt;
  logic          chv_r, chv_nxt, oe_n_r, stat_r, stat_nxt;
  logic [7:0]    chd_r, chd_nxt;

  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    hex_ch = (n < 4'ha) ? gpio_report_pkg::CH_0 + {4'h0, n}
                        : gpio_report_pkg::CH_A10 + {4'h0, n};
  endfunction

  function automatic int msg_len(input gpio_report_pkg::msg_t m);
    case (m)
      gpio_report_pkg::MSG_OK:  msg_len = gpio_report_pkg::OK_LEN;
      gpio_report_pkg::MSG_ERR: msg_len = gpio_report_pkg::ERR_LEN;
      default:                  msg_len = gpio_report_pkg::REP_LEN;
    endcase
  endfunction

  function automatic logic [7:0] char_at(input gpio_report_pkg::msg_t m,
    input int i, input logic [15:0] v, input logic [63:0] s);
    char_at = '0;
    case (m)
      gpio_report_pkg::MSG_OK: begin
        char_at = gpio_report_pkg::MSG_OK_TXT[8*(msg_len(m)-1-i) +: 8];
      end
      gpio_report_pkg::MSG_ERR: begin
        char_at = gpio_report_pkg::MSG_ERR_TXT[8*(msg_len(m)-1-i) +: 8];
      end
      gpio_report_pkg::MSG_REP: begin
        if (i < gpio_report_pkg::REP_HEX_AT) begin
          char_at = gpio_report_pkg::TAG_TXT[8*(2-i) +: 8];
        end else if (i < gpio_report_pkg::REP_US_AT) begin
          char_at = hex_ch(v[4*(gpio_report_pkg::REP_US_AT-1-i) +: 4]);
        end else if (i < gpio_report_pkg::REP_SRC_AT) begin
          char_at = gpio_report_pkg::CH_US;
        end else if (i < gpio_report_pkg::REP_CR_AT) begin
          char_at = hex_ch(s[4*(gpio_report_pkg::REP_CR_AT-1-i) +: 4]);
        end else if (i == gpio_report_pkg::REP_CR_AT) begin
          char_at = gpio_report_pkg::CH_CR;
        end else begin
          char_at = gpio_report_pkg::CH_LF;
        end
      end
      default: char_at = '0;
    endcase
  endfunction

  always_comb begin
    msg_nxt = msg_r;
    idx_nxt = idx_r;
    rxv_nxt = rxv_r;
    src_nxt = src_r;
    gpo_nxt = gpo_r;
    if (chv_r && I_CH_READY) begin
      if (int'(idx_r) == msg_len(msg_r) - 1) begin
        msg_nxt = gpio_report_pkg::MSG_NONE;
        idx_nxt = '0;
      end else begin
        idx_nxt = idx_r + 1'b1;
      end
    end
    if (chk_done) begin
      msg_nxt = net_s ? gpio_report_pkg::MSG_OK
                      : gpio_report_pkg::MSG_ERR;
      idx_nxt = '0;
    end else if (I_RX_VALID && msg_nxt == gpio_report_pkg::MSG_NONE) begin
      msg_nxt = gpio_report_pkg::MSG_REP;
      idx_nxt = '0;
      rxv_nxt = I_RX_DATA;
      src_nxt = I_RX_SRC;
    end
    if (I_RX_VALID && ctrl_r[1:0] == gpio_report_pkg::DIR_OUT) begin
      gpo_nxt = I_RX_DATA;
    end
    chv_nxt = (msg_nxt != gpio_report_pkg::MSG_NONE);
    chd_nxt = char_at(msg_nxt, int'(idx_nxt), rxv_nxt, src_nxt);
    // fast flicker without network, one blink a second without target
    if (!net_s) begin
      stat_nxt = tick_r ? !stat_r : stat_r;
    end else if (!ctrl_r[gpio_report_pkg::C_TGT]) begin
      stat_nxt = (sub_r == '0);
    end else begin
      stat_nxt = 1'b1;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      msg_r  <= gpio_report_pkg::MSG_NONE;
      idx_r  <= '0;
      rxv_r  <= '0;
      src_r  <= '0;
      gpo_r  <= '0;
      chv_r  <= 1'b0;
      chd_r  <= '0;
      oe_n_r <= 1'b1;
      stat_r <= 1'b0;
    end else begin
      msg_r  <= msg_nxt;
      idx_r  <= idx_nxt;
      rxv_r  <= rxv_nxt;
      src_r  <= src_nxt;
      gpo_r  <= gpo_nxt;
      chv_r  <= chv_nxt;
      chd_r  <= chd_nxt;
      oe_n_r <= (ctrl_r[1:0] != gpio_report_pkg::DIR_OUT);
      stat_r <= stat_nxt;
    end
  end

  assign O_CH_VALID   = chv_r;
  assign O_CH_DATA    = chd_r;
  assign O_GPIO       = gpo_r;
  assign O_GPIO_OE_N  = oe_n_r;
  assign O_STATUS_LED = stat_r;

  dir_input_a: assert property (dir_in |=> O_GPIO_OE_N)
    else $error("port driven while set as input");
  report_tag_a: assert property (!chk_done && I_RX_VALID
    && msg_r == gpio_report_pkg::MSG_NONE |=> O_CH_VALID
    && O_CH_DATA == gpio_report_pkg::TAG_TXT[23:16])
    else $error("report did not start with its tag");
  report_any_a: assert property (!chk_done && I_RX_VALID
    && msg_r == gpio_report_pkg::MSG_NONE |=> msg_r == gpio_report_pkg::MSG_REP)
    else $error("received report not printed");
  port_drive_a: assert property (I_RX_VALID
    && ctrl_r[1:0] == gpio_report_pkg::DIR_OUT && $stable(ctrl_r)
    |=> O_GPIO == $past(I_RX_DATA) && !O_GPIO_OE_N)
    else $error("received value not driven on port");
  start_msg_a: assert property (chk_done |=> O_CH_VALID
    && O_CH_DATA == gpio_report_pkg::MSG_OK_TXT[8*gpio_report_pkg::OK_LEN-1 -: 8])
    else $error("start message missing after check");
  led_on_a: assert property (ctrl_r[gpio_report_pkg::C_TGT] && net_s
    |=> O_STATUS_LED)
    else $error("status led not steady with target set");

  // reads answer in the next cycle only
  always_ff @(posedge I_MCLK) begin
    if (I_RST || !I_RD) begin
      O_RDATA <= '0;
    end else if (I_ADDR == gpio_report_pkg::A_CTRL) begin
      O_RDATA <= 16'(ctrl_r);
    end else if (I_ADDR == gpio_report_pkg::A_INTERVAL) begin
      O_RDATA <= 16'(intv_r);
    end else if (I_ADDR == gpio_report_pkg::A_STATUS) begin
      O_RDATA <= 16'({err_r, ok_r, busy_r, net_s, sleep_r,
                      phase_r == gpio_report_pkg::PH_CHECK});
    end else if (I_ADDR == gpio_report_pkg::A_RXVAL) begin
      O_RDATA <= rxv_r;
    end else if (I_ADDR == gpio_report_pkg::A_COUNT) begin
      O_RDATA <= cnt_r;
    end else begin
      O_RDATA <= '0;
    end
  end
endmodule

// ---- far_side_model.sv ----
/*
  far_side_model: the paired radio and the serial sink behind the block.
  assumes one shared clock; answers every send after a few cycles.
*/
`timescale 1ns/100ps
module far_side_model (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_tx_valid,
  output logic      o_link_done,
  output logic      o_link_ok,
  output logic      o_ch_ready
);
  logic [3:0] wait_r;
  assign o_link_ok = 1'b1;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wait_r      <= 4'h0;
      o_link_done <= 1'b0;
      o_ch_ready  <= 1'b0;
    end else begin
      // sink stalls every other cycle so chars must hold
      o_ch_ready  <= ~o_ch_ready;
      o_link_done <= (wait_r == 4'h1);
      if (i_tx_valid)
        wait_r <= 4'h6;
      else if (wait_r != 4'h0)
        wait_r <= wait_r - 4'h1;
    end
  end
endmodule

// ---- gpio_report_select_test.sv ----
/*
  gpio_report_select_test: register-call tests of the port report block.
  assumes FAST_CYC of 4, so one second is 40 cycles.
*/
`timescale 1ns/100ps
module gpio_report_select_test;
  localparam logic [15:0] RV = 16'h007f;
  localparam logic [63:0] RS = 64'h00a1b2c3d4e5f607;
  logic clk, rst, wr_s, rd_s, key_n, wake_n, rx_v, done, ok, rdy, net;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, gpo, gpio, txd;
  logic [1:0] txk;
  logic [7:0] chd;
  logic oe_n, txv, chv, sled, okled, eled, slp;
  logic [15:0] d;
  logic [1:0] tx_k[$];
  logic [15:0] tx_d[$];
  int tx_t[$];
  logic [7:0] ch_q[$];
  int n_errors = 0, compares = 0, cyc = 0, k, n;
  gpio_report_select #(.FAST_CYC(4)) dut_u (.I_MCLK(clk), .I_RST(rst),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s),
    .O_RDATA(rdata), .I_KEY_N(key_n), .I_WAKE_N(wake_n), .I_NET_UP(net),
    .I_GPIO(gpio), .O_GPIO(gpo), .O_GPIO_OE_N(oe_n), .I_ADC(16'h0123),
    .O_TX_VALID(txv), .O_TX_KIND(txk), .O_TX_DATA(txd),
    .I_LINK_DONE(done), .I_LINK_OK(ok), .I_RX_VALID(rx_v),
    .I_RX_DATA(RV), .I_RX_SRC(RS), .O_CH_VALID(chv), .O_CH_DATA(chd),
    .I_CH_READY(rdy), .O_STATUS_LED(sled), .O_OK_LED(okled),
    .O_ERR_LED(eled), .O_SLEEP(slp));
  far_side_model far_u (.i_clk(clk), .i_rst(rst), .i_tx_valid(txv),
    .o_link_done(done), .o_link_ok(ok), .o_ch_ready(rdy));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (txv === 1'b1) begin
      tx_k.push_back(txk);
      tx_d.push_back(txd);
      tx_t.push_back(cyc);
    end
    if (chv === 1'b1 && rdy === 1'b1)
      ch_q.push_back(chd);
  end
  task automatic check(input string nm, input logic [63:0] e, s);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a; wdata <= v; wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a; rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_q(input int ntx, nch);
    for (int i = 0; i < 3000; i++) begin
      if (tx_k.size() >= ntx && ch_q.size() >= nch) return;
      @(posedge clk);
    end
    check("wait", 1, 0);
    wrap_up();
  endtask
  function automatic logic [7:0] hx(input logic [3:0] v);
    return v < 4'ha ? gpio_report_pkg::CH_0 + {4'h0, v}
                    : gpio_report_pkg::CH_A10 + {4'h0, v};
  endfunction
  function automatic logic [7:0] rep_ch(input int i);
    if (i < 3) return gpio_report_pkg::TAG_TXT[8*(2-i)+:8];
    if (i < 7) return hx(RV[4*(6-i)+:4]);
    if (i == 7) return gpio_report_pkg::CH_US;
    if (i < 24) return hx(RS[4*(23-i)+:4]);
    return i == 24 ? gpio_report_pkg::CH_CR : gpio_report_pkg::CH_LF;
  endfunction
  initial begin
    rst = 1'b1; wr_s = 1'b0; rd_s = 1'b0; key_n = 1'b1; wake_n = 1'b1;
    rx_v = 1'b0; addr = 4'h0; wdata = 16'h0000; gpio = RV; net = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wr(gpio_report_pkg::A_CTRL, 16'h0005);
    rd(gpio_report_pkg::A_CTRL, d);
    check("ctrl in check", 0, d);
    rd(gpio_report_pkg::A_STATUS, d);
    check("checking", 1, d[gpio_report_pkg::S_CHECK]);
    wait_q(0, gpio_report_pkg::OK_LEN);
    for (k = 0; k < gpio_report_pkg::OK_LEN; k++)
      check("start msg", gpio_report_pkg::MSG_OK_TXT[
        8*(gpio_report_pkg::OK_LEN-1-k)+:8], ch_q[k]);
    ch_q.delete();
    wr(gpio_report_pkg::A_CTRL, 16'h0005);
    @(posedge clk);
    key_n <= 1'b0;
    wait_q(1, 0);
    key_n <= 1'b1;
    check("key kind", 2'h1, tx_k[0]);
    check("key data", RV, tx_d[0]);
    repeat (12) @(posedge clk);
    check("ok led", 1, okled);
    check("err led", 0, eled);
    wr(gpio_report_pkg::A_INTERVAL, 16'h0001);
    wr(gpio_report_pkg::A_CTRL, 16'h0009);
    wait_q(3, 0);
    check("intv kind", 2'h1, tx_k[2]);
    check("intv data", RV, tx_d[2]);
    n = tx_t[2] - tx_t[1];
    check("period", 1, n >= 36 && n <= 44);
    wr(gpio_report_pkg::A_CTRL, 16'h0019);
    n = tx_k.size();
    wait_q(n + 1, 0);
    check("cnt kind", 2'h3, tx_k[n]);
    check("cnt data", 16'h0001, tx_d[n]);
    wr(gpio_report_pkg::A_CTRL, 16'h0009);
    n = tx_k.size();
    wait_q(n + 1, 0);
    check("port again", 2'h1, tx_k[n]);
    wr(gpio_report_pkg::A_CTRL, 16'h0008);
    n = tx_k.size();
    wait_q(n + 1, 0);
    check("adc kind", 2'h2, tx_k[n]);
    check("adc data", 16'h0123, tx_d[n]);
    // key only, port not an input: a plain key event goes out
    wr(gpio_report_pkg::A_CTRL, 16'h0004);
    repeat (12) @(posedge clk);
    key_n <= 1'b0;
    n = tx_k.size();
    wait_q(n + 1, 0);
    key_n <= 1'b1;
    check("key only", 2'h0, tx_k[n]);
    check("key only data", 16'h0000, tx_d[n]);
    wr(gpio_report_pkg::A_CTRL, 16'h0002);
    @(posedge clk);
    rx_v <= 1'b1;
    @(posedge clk);
    rx_v <= 1'b0;
    wait_q(0, gpio_report_pkg::REP_LEN);
    for (k = 0; k < gpio_report_pkg::REP_LEN; k++)
      check("report", rep_ch(k), ch_q[k]);
    check("port out", RV, gpo);
    check("port oe_n", 0, oe_n);
    wr(gpio_report_pkg::A_CTRL, 16'h0060);
    repeat (3) @(posedge clk);
    check("sleep", 1, slp);
    check("led on", 1, sled);
    check("ok led off", 0, okled);
    wr(gpio_report_pkg::A_CTRL, 16'h0000);
    rd(gpio_report_pkg::A_CTRL, d);
    check("ctrl asleep", 16'h0060, d);
    wake_n <= 1'b0;
    for (k = 0; k < 20 && slp !== 1'b0; k++) @(posedge clk);
    wake_n <= 1'b1;
    check("awake", 0, slp);
    for (k = 0; k < 60 && slp !== 1'b1; k++) @(posedge clk);
    check("resleep", 1, k >= 34 && k <= 42);
    // losing the network makes the led toggle once per tick
    net <= 1'b0;
    repeat (6) @(posedge clk);
    n = sled;
    repeat (4) @(posedge clk);
    check("flicker", !n[0], sled);
    // second power-up with no network ends in the error banner
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    ch_q.delete();
    rd(gpio_report_pkg::A_STATUS, d);
    check("rechecking", 16'h0001, d);
    wait_q(0, gpio_report_pkg::ERR_LEN);
    for (k = 0; k < gpio_report_pkg::ERR_LEN; k++)
      check("error msg", gpio_report_pkg::MSG_ERR_TXT[
        8*(gpio_report_pkg::ERR_LEN-1-k)+:8], ch_q[k]);
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk);
    check("timeout", 1, 0);
    wrap_up();
  end
endmodule
